//--- hdl/ias_params.svh
`ifndef IAS_PARAMS_SVH
`define IAS_PARAMS_SVH

// Core clock and identification times
`define IAS_CLK_PERIOD_NS 10
`define IAS_NMI_ID_NS 20
`define IAS_IRL_ID_NS 30
`define IAS_GA_ID_NS 15
`define IAS_GB_ID_NS 10
`define IAS_CYC_UP(ns) (((ns) + `IAS_CLK_PERIOD_NS - 1) / `IAS_CLK_PERIOD_NS)

// Source counts: group A first, then group B
`define IAS_N_GA 2
`define IAS_N_GB 6
`define IAS_EXT_VEC_WAIT 3

// Register byte offsets
`define IAS_OFS_CTRL 8'h00
`define IAS_OFS_PRIO_FIRST 8'h04
`define IAS_OFS_PRIO_LAST 8'h08
`define IAS_OFS_VEC_BASE 8'h0c
`define IAS_OFS_INT_STATUS 8'h10
`define IAS_OFS_INT_MASK 8'h14
`define IAS_OFS_STATE 8'h18

// Field positions
`define IAS_CTRL_EXT_VEC 0
`define IAS_CTRL_NMI_RISE 1
`define IAS_CTRL_NMI_LEVEL 8
`define IAS_INT_ACCEPT 0
`define IAS_INT_NMI 1

// Reset values and vectors
`define IAS_RST_CTRL 2'h0
`define IAS_RST_PRIO 16'h0000
`define IAS_RST_VEC_BASE 8'h48
`define IAS_RST_INT 2'h0
`define IAS_NMI_VECTOR 8'h0b
`define IAS_AUTO_VEC_BASE 8'h40

`endif

//--- hdl/ias_pkg.sv
package ias_pkg;
    // Acceptance sequence
    typedef enum {IAS_IDLE, IAS_VEC_WAIT, IAS_DONE} ias_state_t;
    // Class of the winning source
    typedef enum logic [1:0] {IAS_SRC_NONE, IAS_SRC_NMI, IAS_SRC_IRL, IAS_SRC_PER} ias_src_t;
endpackage : ias_pkg

//--- hdl/ias_top.sv
// Summary of operation
// - Highest programmed level wins, others stay pending.
// - Equal levels resolved by fixed default order.
// - Request CPU only when level exceeds mask.
// - Accepted level loaded into CPU mask bits.
// - External vector taken from low data lines.
// - NMI two cycles, encoded pins three cycles.
// - Group A two cycles, group B one.
// - Minimum totals 10, 11, 9.5, 9 states.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`include "ias_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ias_top
    import ias_pkg::*;
#(
    parameter int N_GA = `IAS_N_GA,
    parameter int N_GB = `IAS_N_GB
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic nmi_i,
    input wire logic [3:0] encoded_level_request_pins_n_i,
    input wire logic [N_GA+N_GB-1:0] per_req_i,
    input wire logic [7:0] ext_data_i,
    output logic ext_vec_cycle_o,
    input wire logic [3:0] cpu_mask_level_bits_i,
    output logic cpu_irq_o,
    input wire logic cpu_ack_i,
    output logic acc_valid_o,
    output logic [3:0] acc_level_o,
    output logic [7:0] acc_vector_o
);
    localparam int NP = N_GA + N_GB;
    localparam int NMI_ID = `IAS_CYC_UP(`IAS_NMI_ID_NS);
    // The flag itself is the last stage of the NMI delay
    localparam int NMI_W = NMI_ID - 1;
    localparam int IRL_ID = `IAS_CYC_UP(`IAS_IRL_ID_NS);
    localparam int GA_ID = `IAS_CYC_UP(`IAS_GA_ID_NS);
    localparam int GB_ID = `IAS_CYC_UP(`IAS_GB_ID_NS);

    ias_state_t state;
    logic [1:0] ctrl;
    logic [15:0] prio_first;
    logic [15:0] prio_last;
    logic [7:0] vec_base;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic nmi_s1, nmi_s2, nmi_s3;
    logic [3:0] irl_s1, irl_s2;
    logic [7:0] ext_s1, ext_s2;
    logic [NMI_W-1:0] nmi_line;
    logic [3:0] irl_line [IRL_ID];
    logic [N_GA-1:0] ga_line [GA_ID];
    logic [N_GB-1:0] gb_line [GB_ID];
    logic nmi_flag;
    logic [3:0] irl_now, irl_eff;
    logic [NP-1:0] per_eff;
    logic [3:0] per_lvl [NP];
    logic [4:0] best_lvl;
    ias_src_t best_src;
    logic [7:0] best_idx;
    ias_src_t acc_src;
    logic [7:0] acc_idx;
    logic [3:0] acc_lvl_q;
    logic [1:0] vec_cnt;
    logic acc_ext;
    logic nmi_edge, accept, wb_req, wb_wr;
    logic [31:0] wmask;
    logic [31:0] next_rd;

    // Pin synchronisers; first stages feed only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_s1 <= 1'b0;
            nmi_s2 <= 1'b0;
            nmi_s3 <= 1'b0;
            irl_s1 <= 4'hf;
            irl_s2 <= 4'hf;
            ext_s1 <= 8'h00;
            ext_s2 <= 8'h00;
        end else if (ce_i) begin
            nmi_s1 <= nmi_i;
            nmi_s2 <= nmi_s1;
            nmi_s3 <= nmi_s2;
            irl_s1 <= encoded_level_request_pins_n_i;
            irl_s2 <= irl_s1;
            ext_s1 <= ext_data_i;
            ext_s2 <= ext_s1;
        end
    end

    // Edge selected by software; pins are active low levels
    assign nmi_edge = ctrl[`IAS_CTRL_NMI_RISE] ? (nmi_s2 & ~nmi_s3) : (~nmi_s2 & nmi_s3);
    assign irl_now = ~irl_s2;
    assign accept = cpu_irq_o & cpu_ack_i;

    // Identification delay lines per source class
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_line <= '0;
            for (int k = 0; k < IRL_ID; k++) irl_line[k] <= 4'h0;
            for (int k = 0; k < GA_ID; k++) ga_line[k] <= '0;
            for (int k = 0; k < GB_ID; k++) gb_line[k] <= '0;
        end else if (ce_i) begin
            nmi_line <= NMI_W'({nmi_line, nmi_edge});
            irl_line[0] <= irl_now;
            for (int k = 1; k < IRL_ID; k++) irl_line[k] <= irl_line[k-1];
            ga_line[0] <= per_req_i[N_GA-1:0];
            for (int k = 1; k < GA_ID; k++) ga_line[k] <= ga_line[k-1];
            gb_line[0] <= per_req_i[NP-1:N_GA];
            for (int k = 1; k < GB_ID; k++) gb_line[k] <= gb_line[k-1];
        end
    end

    // Level inputs count once old enough and still present, so a
    // withdrawn request vanishes at once rather than firing late
    assign irl_eff = (irl_line[IRL_ID-1] == irl_now) ? irl_now : 4'h0;
    assign per_eff = {gb_line[GB_ID-1] & per_req_i[NP-1:N_GA],
                      ga_line[GA_ID-1] & per_req_i[N_GA-1:0]};

    // NMI flag: set wins over the clear on acceptance
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_flag <= 1'b0;
        end else if (ce_i) begin
            if (nmi_line[NMI_W-1]) begin
                nmi_flag <= 1'b1;
            end else if (accept && best_src == IAS_SRC_NMI) begin
                nmi_flag <= 1'b0;
            end
        end
    end

    // Per source level from the two setting registers
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_lvl
            if (g < 4) begin : g_first
                assign per_lvl[g] = prio_first[4*g +: 4];
            end else begin : g_last
                assign per_lvl[g] = prio_last[4*(g-4) +: 4];
            end
        end
    endgenerate

    // Arbitration: scan from lowest default priority up so that
    // a tie goes to the earlier source; NMI sits above all levels
    always_comb begin
        best_lvl = 5'h00;
        best_src = IAS_SRC_NONE;
        best_idx = 8'h00;
        for (int i = NP - 1; i >= 0; i--) begin
            if (per_eff[i] && {1'b0, per_lvl[i]} >= best_lvl && per_lvl[i] != 4'h0) begin
                best_lvl = {1'b0, per_lvl[i]};
                best_src = IAS_SRC_PER;
                best_idx = 8'(i);
            end
        end
        if (irl_eff != 4'h0 && {1'b0, irl_eff} >= best_lvl) begin
            best_lvl = {1'b0, irl_eff};
            best_src = IAS_SRC_IRL;
            best_idx = 8'h00;
        end
        if (nmi_flag) begin
            best_lvl = 5'h10;
            best_src = IAS_SRC_NMI;
            best_idx = 8'h00;
        end
    end

    // Request to the CPU only above the mask; held while it waits.
    // Quiet in the answer cycle, since the CPU mask is not loaded yet
    assign cpu_irq_o = (state == IAS_IDLE) && !acc_valid_o
                       && (best_lvl > {1'b0, cpu_mask_level_bits_i});

    // Acceptance sequence and answer to the CPU
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= IAS_IDLE;
            acc_src <= IAS_SRC_NONE;
            acc_idx <= 8'h00;
            acc_lvl_q <= 4'h0;
            acc_ext <= 1'b0;
            vec_cnt <= 2'h0;
            ext_vec_cycle_o <= 1'b0;
            acc_valid_o <= 1'b0;
            acc_level_o <= 4'h0;
            acc_vector_o <= 8'h00;
        end else if (ce_i) begin
            acc_valid_o <= 1'b0;
            case (state)
                IAS_IDLE: begin
                    if (accept) begin
                        acc_src <= best_src;
                        acc_idx <= best_idx;
                        acc_lvl_q <= best_lvl[4] ? 4'hf : best_lvl[3:0];
                        vec_cnt <= 2'(`IAS_EXT_VEC_WAIT - 1);
                        if (best_src == IAS_SRC_IRL && ctrl[`IAS_CTRL_EXT_VEC]) begin
                            acc_ext <= 1'b1;
                            ext_vec_cycle_o <= 1'b1;
                            state <= IAS_VEC_WAIT;
                        end else begin
                            acc_ext <= 1'b0;
                            state <= IAS_DONE;
                        end
                    end
                end
                IAS_VEC_WAIT: begin
                    // Data lines settle through the synchroniser
                    if (vec_cnt == 2'h0) begin
                        ext_vec_cycle_o <= 1'b0;
                        state <= IAS_DONE;
                    end else begin
                        vec_cnt <= vec_cnt - 2'h1;
                    end
                end
                IAS_DONE: begin
                    acc_valid_o <= 1'b1;
                    acc_level_o <= acc_lvl_q;
                    case (acc_src)
                        IAS_SRC_NMI: acc_vector_o <= `IAS_NMI_VECTOR;
                        IAS_SRC_IRL: begin
                            if (acc_ext) begin
                                acc_vector_o <= ext_s2;
                            end else begin
                                acc_vector_o <= `IAS_AUTO_VEC_BASE + 8'((acc_lvl_q - 4'h1) >> 1);
                            end
                        end
                        default: acc_vector_o <= vec_base + acc_idx;
                    endcase
                    state <= IAS_IDLE;
                end
                default: state <= IAS_IDLE;
            endcase
        end
    end

    // Bus decode; one wait state, and writes land at the ack edge
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Software writable settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `IAS_RST_CTRL;
            prio_first <= `IAS_RST_PRIO;
            prio_last <= `IAS_RST_PRIO;
            vec_base <= `IAS_RST_VEC_BASE;
            int_mask <= `IAS_RST_INT;
        end else if (ce_i && wb_wr) begin
            case (wb_adr_i)
                `IAS_OFS_CTRL: begin
                    if (wb_sel_i[0]) ctrl <= wb_dat_i[1:0];
                end
                `IAS_OFS_PRIO_FIRST: prio_first <= (prio_first & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                `IAS_OFS_PRIO_LAST: prio_last <= (prio_last & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                `IAS_OFS_VEC_BASE: begin
                    if (wb_sel_i[0]) vec_base <= wb_dat_i[7:0];
                end
                `IAS_OFS_INT_MASK: begin
                    if (wb_sel_i[0]) int_mask <= wb_dat_i[1:0];
                end
                default: ;
            endcase
        end
    end

    // Sticky events; a new event beats a same-cycle write of one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_status <= `IAS_RST_INT;
        end else if (ce_i) begin
            for (int b = 0; b < 2; b++) begin
                if ((b == `IAS_INT_ACCEPT && accept) || (b == `IAS_INT_NMI && nmi_line[NMI_W-1])) begin
                    int_status[b] <= 1'b1;
                end else if (wb_wr && wb_sel_i[0] && wb_adr_i == `IAS_OFS_INT_STATUS && wb_dat_i[b]) begin
                    int_status[b] <= 1'b0;
                end
            end
        end
    end

    assign irq_o = |(int_status & int_mask);

    // Read mux; unmapped addresses read zero and still answer
    always_comb begin
        next_rd = 32'h0000_0000;
        case (wb_adr_i)
            `IAS_OFS_CTRL: begin
                next_rd[1:0] = ctrl;
                next_rd[`IAS_CTRL_NMI_LEVEL] = nmi_s2;
            end
            `IAS_OFS_PRIO_FIRST: next_rd[15:0] = prio_first;
            `IAS_OFS_PRIO_LAST: next_rd[15:0] = prio_last;
            `IAS_OFS_VEC_BASE: next_rd[7:0] = vec_base;
            `IAS_OFS_INT_STATUS: next_rd[1:0] = int_status;
            `IAS_OFS_INT_MASK: next_rd[1:0] = int_mask;
            `IAS_OFS_STATE: next_rd = {8'h00, acc_vector_o, 3'h0, best_lvl, 4'h0, irl_eff};
            default: next_rd = 32'h0000_0000;
        endcase
    end

    // Ack and read data one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            if (wb_req) wb_dat_o <= next_rd;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    irq_above_mask_a: assert property (cpu_irq_o |-> best_lvl > {1'b0, cpu_mask_level_bits_i})
        else $error("request issued at or below mask");
    irq_blocked_a: assert property ((state == IAS_IDLE && !acc_valid_o
        && best_lvl > {1'b0, cpu_mask_level_bits_i})
        |-> cpu_irq_o)
        else $error("request above mask not issued");
    nmi_wins_a: assert property (nmi_flag |-> best_src == IAS_SRC_NMI && best_lvl == 5'h10)
        else $error("nmi did not win");
    tie_order_a: assert property ((!nmi_flag && irl_eff != 4'h0 && best_lvl == {1'b0, irl_eff})
        |-> best_src == IAS_SRC_IRL)
        else $error("tie not resolved to pins");
    accept_level_a: assert property ((accept && !(best_src == IAS_SRC_IRL && ctrl[0]))
        |-> ##2 acc_valid_o && acc_level_o == $past(best_lvl[4] ? 4'hf : best_lvl[3:0], 2))
        else $error("accepted level not presented");
    ext_vector_a: assert property ((accept && best_src == IAS_SRC_IRL && ctrl[0])
        |-> ##1 ext_vec_cycle_o [*3] ##1 !ext_vec_cycle_o
        ##1 acc_valid_o && acc_vector_o == $past(ext_s2))
        else $error("external vector not taken");
    nmi_latency_a: assert property ((nmi_edge && !nmi_flag && state == IAS_IDLE)
        |-> !nmi_flag ##NMI_ID nmi_flag)
        else $error("nmi identification time wrong");
    irl_latency_a: assert property ((irl_eff != 4'h0) |-> $past(irl_now, IRL_ID) == irl_eff)
        else $error("pin level identified too early");
    gb_latency_a: assert property (per_eff[NP-1:N_GA] == (gb_line[GB_ID-1] & per_req_i[NP-1:N_GA])
        && $past(per_req_i[N_GA], GB_ID) == gb_line[GB_ID-1][0])
        else $error("group b identification time wrong");
    pend_kept_a: assert property ((cpu_irq_o && !cpu_ack_i) ##1 ($stable(best_lvl)
        && $stable(cpu_mask_level_bits_i)) |-> cpu_irq_o)
        else $error("pending request dropped");
    wb_ack_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");

endmodule : ias_top

`default_nettype wire

//--- dv/ias_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ias_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_i,
    input wire logic vec_cyc_i,
    input wire logic acc_i,
    input wire logic [3:0] lvl_i,
    input wire logic ld_i,
    input wire logic [3:0] ld_val_i,
    input wire logic [7:0] vec_i,
    output logic ack_o,
    output logic [3:0] mask_o,
    output logic [7:0] data_o
);
    logic busy;
    logic [2:0] seq;
    // One ack per request seen at decode; none while saving or fetching
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            busy <= 1'b0;
        end else begin
            ack_o <= irq_i && !busy && !ack_o && seq == 3'h0;
            busy <= (busy && !acc_i) || (ack_o && irq_i);
        end
    end
    // Status save, counter save, vector read, then first fetch
    always_ff @(posedge clk_i) begin
        if (rst_i) seq <= 3'h0;
        else if (acc_i) seq <= 3'h1;
        else if (seq != 3'h0) seq <= (seq == 3'h5) ? 3'h0 : seq + 3'h1;
    end
    // Mask takes the accepted level; bench may lower it as a handler would
    always_ff @(posedge clk_i) begin
        if (rst_i) mask_o <= 4'h0;
        else if (acc_i) mask_o <= lvl_i;
        else if (ld_i) mask_o <= ld_val_i;
    end
    // Released lines toggle so a stale vector cannot pass by luck
    always_ff @(posedge clk_i) begin
        if (rst_i) data_o <= 8'h00;
        else if (busy || ack_o || vec_cyc_i) data_o <= vec_i;
        else data_o <= ~data_o;
    end
endmodule : ias_cpu_model
`default_nettype wire

//--- dv/tb.sv
`include "ias_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic nmi = 1'b1, cpu_ack, irq, cpu_irq, vcyc, acc_v, ack, ld = 1'b0;
    logic [7:0] adr = 8'h00, per = 8'h00, ext_data, acc_vec, vec = 8'h00;
    logic [3:0] pins = 4'hf, mask, acc_lvl, ld_val = 4'h0;
    logic [31:0] dwr = 32'h0, drd, q;
    int failures = 0, checked = 0, cb, ca, cn, cp, v;

    // Core clock
    always #5 clk = ~clk;

    ias_top ias_top_inst (
        .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dwr),
        .wb_dat_o(drd), .wb_ack_o(ack), .irq_o(irq), .nmi_i(nmi),
        .encoded_level_request_pins_n_i(pins), .per_req_i(per),
        .ext_data_i(ext_data), .ext_vec_cycle_o(vcyc),
        .cpu_mask_level_bits_i(mask), .cpu_irq_o(cpu_irq), .cpu_ack_i(cpu_ack),
        .acc_valid_o(acc_v), .acc_level_o(acc_lvl), .acc_vector_o(acc_vec)
    );

    ias_cpu_model ias_cpu_model_inst (
        .clk_i(clk), .rst_i(rst), .irq_i(cpu_irq), .vec_cyc_i(vcyc),
        .acc_i(acc_v), .lvl_i(acc_lvl), .ld_i(ld), .ld_val_i(ld_val),
        .vec_i(vec), .ack_o(cpu_ack), .mask_o(mask), .data_o(ext_data)
    );

    task automatic end_sim();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Classic single cycle; ack sampled at the rising edge itself
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dwr <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = drd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            failures++;
            end_sim();
        end
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd

    // Waits for one acceptance, counting external vector wait cycles
    task automatic wacc(input logic [3:0] l, input logic [7:0] e, output int vc);
        int n;
        n = 0;
        vc = 0;
        do begin
            @(negedge clk);
            n++;
            if (vcyc === 1'b1) vc++;
        end while (acc_v !== 1'b1 && n < 60);
        if (acc_v !== 1'b1) begin
            failures++;
            end_sim();
        end else begin
            chk({28'h0, acc_lvl}, {28'h0, l});
            chk({24'h0, acc_vec}, {24'h0, e});
        end
    endtask : wacc

    // Sources change first; mask follows once stale identification has drained
    task automatic src(input logic [7:0] p, input logic [3:0] m);
        @(posedge clk);
        per <= p;
        nmi <= 1'b1;
        pins <= 4'hf;
        repeat (8) @(posedge clk);
        ld <= 1'b1;
        ld_val <= m;
        @(posedge clk);
        ld <= 1'b0;
    endtask : src

    // Cycles from raising a source until the CPU request shows
    task automatic meas(input int k, output int c);
        @(posedge clk);
        case (k)
            0: per <= 8'h04;
            1: per <= 8'h01;
            2: nmi <= 1'b0;
            default: pins <= 4'h9;
        endcase
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (cpu_irq !== 1'b1 && c < 40);
        if (cpu_irq !== 1'b1) begin
            failures++;
            end_sim();
        end
    endtask : meas

    task automatic t_regs();
        rd(`IAS_OFS_VEC_BASE, 32'h48);
        rd(`IAS_OFS_CTRL, 32'h100);
        wb(1'b1, 8'h20, 32'hffff_ffff, q);
        rd(8'h20, 32'h0);
    endtask : t_regs

    task automatic t_prio();
        wb(1'b1, `IAS_OFS_PRIO_FIRST, 32'h0000_0955, q);
        @(posedge clk);
        per <= 8'h07;
        wacc(4'h9, 8'h4a, v);
        repeat (3) begin
            @(negedge clk);
            chk({31'h0, cpu_irq}, 32'h0);
        end
        src(8'h07, 4'h8);
        wacc(4'h9, 8'h4a, v);
        src(8'h03, 4'h0);
        wacc(4'h5, 8'h48, v);
        src(8'h02, 4'h0);
        wacc(4'h5, 8'h49, v);
        src(8'h00, 4'h0);
    endtask : t_prio

    // Only differences are judged, so the shared pipeline offset cancels
    task automatic t_lat();
        meas(0, cb);
        wacc(4'h9, 8'h4a, v);
        src(8'h00, 4'h0);
        meas(1, ca);
        wacc(4'h5, 8'h48, v);
        src(8'h00, 4'h0);
        meas(2, cn);
        wacc(4'hf, `IAS_NMI_VECTOR, v);
        src(8'h00, 4'h0);
        meas(3, cp);
        wacc(4'h6, 8'h42, v);
        src(8'h00, 4'h0);
        chk(32'(ca - cb), 32'h1);
        chk(32'(cn - cb), 32'h3);
        chk(32'(cp - cb), 32'h4);
    endtask : t_lat

    task automatic t_ext();
        wb(1'b1, `IAS_OFS_CTRL, 32'h1, q);
        @(posedge clk);
        vec <= 8'h35;
        pins <= 4'h3;
        wacc(4'hc, 8'h35, v);
        chk(32'(v), 32'h3);
        src(8'h00, 4'h0);
        wb(1'b1, `IAS_OFS_CTRL, 32'h0, q);
    endtask : t_ext

    task automatic t_irq();
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, `IAS_OFS_INT_MASK, 32'h1, q);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, `IAS_OFS_INT_STATUS, 32'h1, q);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        rd(`IAS_OFS_INT_STATUS, 32'h2);
        wb(1'b1, `IAS_OFS_INT_MASK, 32'h3, q);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, `IAS_OFS_INT_STATUS, 32'h3, q);
        rd(`IAS_OFS_INT_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask : t_irq

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_prio();
        t_lat();
        t_ext();
        t_irq();
        end_sim();
    end
endmodule : tb
`default_nettype wire
